// ### logic/igr_pkg.sv
// Purpose: shared constants for the image geometry and region-of-interest stage
// Assumes: byte addresses on a 32-bit APB bus, one 16-bit container per pixel
// Notes:   array size and converter depth are fixed for this build
package igr_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_STATUS    = 8'h04;
    localparam logic [7:0] OFS_H_COMBINE = 8'h08;
    localparam logic [7:0] OFS_V_COMBINE = 8'h0C;
    localparam logic [7:0] OFS_H_SUB     = 8'h10;
    localparam logic [7:0] OFS_V_SUB     = 8'h14;
    localparam logic [7:0] OFS_COL_START = 8'h18;
    localparam logic [7:0] OFS_ROW_START = 8'h1C;
    localparam logic [7:0] OFS_CROP_COLS = 8'h20;
    localparam logic [7:0] OFS_CROP_ROWS = 8'h24;
    localparam logic [7:0] OFS_STRIDE    = 8'h28;
    localparam logic [7:0] OFS_LAYOUT    = 8'h2C;
    localparam logic [7:0] OFS_ARR_COLS  = 8'h30;
    localparam logic [7:0] OFS_ARR_ROWS  = 8'h34;
    localparam logic [7:0] OFS_RED_COLS  = 8'h38;
    localparam logic [7:0] OFS_RED_ROWS  = 8'h3C;
    localparam logic [7:0] OFS_TAPS      = 8'h40;
    localparam logic [7:0] OFS_CONV_TAPS = 8'h44;
    localparam logic [7:0] OFS_CODING    = 8'h48;
    localparam logic [7:0] OFS_BITS      = 8'h4C;
    localparam logic [7:0] OFS_MASK      = 8'h50;
    localparam logic [7:0] OFS_FLOOR     = 8'h54;
    localparam logic [7:0] OFS_CEILING   = 8'h58;

    // control, status and layout bit positions
    localparam int CTRL_RUN      = 0;
    localparam int CTRL_H_MIRROR = 1;
    localparam int CTRL_V_MIRROR = 2;
    localparam int STAT_BUSY     = 0;
    localparam int STAT_CLAMPED  = 1;
    localparam int STAT_FRAMES   = 8;
    localparam int LAYOUT_BITS   = 0;
    localparam int LAYOUT_MASK   = 8;
    localparam int LAYOUT_CODING = 16;

    // array geometry
    localparam int         COL_W      = 6;
    localparam int         ROW_W      = 5;
    localparam logic [6:0] ARRAY_COLS = 7'h40;
    localparam logic [5:0] ARRAY_ROWS = 6'h20;
    localparam logic [2:0] COL_LOG    = 3'h6;
    localparam logic [2:0] ROW_LOG    = 3'h5;
    localparam int         MEM_DEPTH  = 2048;

    // sample encoding
    localparam logic [7:0]  SAMPLE_BITS   = 8'h10;
    localparam logic [15:0] VALUE_FLOOR   = 16'h0000;
    localparam logic [15:0] VALUE_CEILING = 16'h0FFF;
    localparam logic [7:0]  CODING_MONO   = 8'h00;
    localparam logic [7:0]  CODING_RAW    = 8'h01;
    localparam logic [7:0]  CODING_RGB    = 8'h02;
    localparam logic [7:0]  CODING_YUV    = 8'h03;
    localparam logic [7:0]  MASK_NONE     = 8'h00;
    localparam logic [7:0]  MASK_LAST     = 8'h04;
    localparam logic [3:0]  FACTOR_ONE    = 4'h1;

    typedef enum logic [2:0] {
        S_IDLE, S_FILL, S_ACC, S_LO, S_HI, S_PAD
    } igr_state_e;
endpackage

// ### logic/igr_core.sv
// Purpose: shrink a stored sensor frame, mirror it, crop a region, emit bytes
// Assumes: sensor samples arrive on this clock in raster order
// Notes:   geometry registers act live; change them only while idle
`timescale 1ns/100ps
module igr_core (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        in_valid,
    input  wire logic [15:0] in_data,
    output logic             in_ready,
    output logic             out_valid,
    input  wire logic        out_ready,
    output logic      [7:0]  out_data,
    output logic             out_sof,
    output logic             out_eol,
    output logic             out_eof
);
    function automatic logic [2:0] f_log(input logic [3:0] v);
        case (v)
            4'h2:    f_log = 3'h1;
            4'h4:    f_log = 3'h2;
            4'h8:    f_log = 3'h3;
            default: f_log = 3'h0;
        endcase
    endfunction
    function automatic logic f_pow2(input logic [31:0] v);
        f_pow2 = (v == 32'h1) || (v == 32'h2) || (v == 32'h4) || (v == 32'h8);
    endfunction
    function automatic logic f_tap_ok(input logic [31:0] v);
        f_tap_ok = (v >= 32'h1 && v <= 32'h4) || v == 32'h8 || v == 32'hA;
    endfunction
    logic [2:0]  ctrl_ff,   nxt_ctrl;
    logic [3:0]  hbin_ff,   nxt_hbin;
    logic [3:0]  vbin_ff,   nxt_vbin;
    logic [3:0]  hsub_ff,   nxt_hsub;
    logic [3:0]  vsub_ff,   nxt_vsub;
    logic [6:0]  ccs_ff,    nxt_ccs;
    logic [5:0]  crs_ff,    nxt_crs;
    logic [6:0]  ccols_ff,  nxt_ccols;
    logic [5:0]  crows_ff,  nxt_crows;
    logic [15:0] stride_ff, nxt_stride;
    logic [7:0]  coding_ff, nxt_coding;
    logic [7:0]  mask_ff,   nxt_mask;
    logic [3:0]  taps_ff,   nxt_taps;
    logic [3:0]  ctaps_ff,  nxt_ctaps;
    logic [31:0] prdata_ff, nxt_prdata;
    logic        perr_ff,   nxt_perr;
    igr_pkg::igr_state_e st_ff, nxt_st;
    logic [10:0] fidx_ff,   nxt_fidx;
    logic [6:0]  oc_ff,     nxt_oc;
    logic [5:0]  or_ff,     nxt_or;
    logic [2:0]  bi_ff,     nxt_bi;
    logic [2:0]  bj_ff,     nxt_bj;
    logic [19:0] acc_ff,    nxt_acc;
    logic [15:0] pix_ff,    nxt_pix;
    logic [7:0]  byte_ff,   nxt_byte;
    logic [15:0] pad_ff,    nxt_pad;
    logic [7:0]  frames_ff, nxt_frames;
    logic [15:0] mem [igr_pkg::MEM_DEPTH];
    logic [2:0]  hs, vs;
    logic [6:0]  rc, cs, cw, cw_lim, x, rx;
    logic [5:0]  rr, rs, ch, ch_lim, y, ry;
    logic [5:0]  raw_c;
    logic [4:0]  raw_r;
    logic [10:0] addr;
    logic [19:0] sum;
    logic [15:0] sat, line_bytes, pad;
    logic        clamped, last_col, last_row;
    logic        setup, wr, mem_we;
    logic [31:0] rd_val;
    logic        rd_hit;
    // reduced size from power-of-two factors, a shift instead of a divider
    always_comb begin
        hs = 3'(f_log(hbin_ff) + f_log(hsub_ff));
        vs = 3'(f_log(vbin_ff) + f_log(vsub_ff));
        rc = igr_pkg::ARRAY_COLS >> hs;
        rr = igr_pkg::ARRAY_ROWS >> vs;
    end
    // crop clamped into the reduced image
    always_comb begin
        cs     = (ccs_ff >= rc) ? 7'(rc - 7'h1) : ccs_ff;
        cw_lim = 7'(rc - cs);
        cw     = (ccols_ff == 7'h0) ? 7'h1 : ((ccols_ff > cw_lim) ? cw_lim : ccols_ff);
        rs     = (crs_ff >= rr) ? 6'(rr - 6'h1) : crs_ff;
        ch_lim = 6'(rr - rs);
        ch     = (crows_ff == 6'h0) ? 6'h1 : ((crows_ff > ch_lim) ? ch_lim : crows_ff);
        clamped = (cs != ccs_ff) || (cw != ccols_ff) || (rs != crs_ff) || (ch != crows_ff);
    end
    // source address: crop offset from (0,0), mirrored, then scaled back
    always_comb begin
        x  = 7'(cs + oc_ff);
        y  = 6'(rs + or_ff);
        rx = ctrl_ff[igr_pkg::CTRL_H_MIRROR] ? 7'(rc - 7'h1 - x) : x;
        ry = ctrl_ff[igr_pkg::CTRL_V_MIRROR] ? 6'(rr - 6'h1 - y) : y;
        raw_c = 6'((rx << hs) + 7'(bi_ff));
        raw_r = 5'((ry << vs) + 6'(bj_ff));
        addr  = {raw_r, raw_c};
        sum   = 20'(acc_ff + 20'(mem[addr]));
        // binned sums saturate so produced codes stay inside the reported range
        sat   = (sum > 20'(igr_pkg::VALUE_CEILING)) ? igr_pkg::VALUE_CEILING
                                                    : sum[15:0];
        line_bytes = 16'({cw, 1'b0});
        // a stride shorter than the line would overlap lines, so it is raised
        pad      = (stride_ff > line_bytes) ? 16'(stride_ff - line_bytes) : 16'h0;
        last_col = (oc_ff == 7'(cw - 7'h1));
        last_row = (or_ff == 6'(ch - 6'h1));
    end
    assign setup  = psel & ~penable;
    assign wr     = psel & penable & pwrite;
    assign pready = 1'b1;
    assign prdata = prdata_ff;
    assign pslverr = perr_ff;
    // read mux; layout is offered whole and split into parts
    always_comb begin
        rd_val = 32'h0;
        rd_hit = 1'b1;
        case (paddr)
            igr_pkg::OFS_CTRL:      rd_val = 32'(ctrl_ff);
            igr_pkg::OFS_STATUS:    rd_val = {16'h0, frames_ff, 6'h0, clamped,
                                              st_ff != igr_pkg::S_IDLE};
            igr_pkg::OFS_H_COMBINE: rd_val = 32'(hbin_ff);
            igr_pkg::OFS_V_COMBINE: rd_val = 32'(vbin_ff);
            igr_pkg::OFS_H_SUB:     rd_val = 32'(hsub_ff);
            igr_pkg::OFS_V_SUB:     rd_val = 32'(vsub_ff);
            igr_pkg::OFS_COL_START: rd_val = 32'(ccs_ff);
            igr_pkg::OFS_ROW_START: rd_val = 32'(crs_ff);
            igr_pkg::OFS_CROP_COLS: rd_val = 32'(ccols_ff);
            igr_pkg::OFS_CROP_ROWS: rd_val = 32'(crows_ff);
            igr_pkg::OFS_STRIDE:    rd_val = 32'(stride_ff);
            igr_pkg::OFS_LAYOUT:    rd_val = {8'h0, coding_ff, mask_ff,
                                              igr_pkg::SAMPLE_BITS};
            igr_pkg::OFS_ARR_COLS:  rd_val = 32'(igr_pkg::ARRAY_COLS);
            igr_pkg::OFS_ARR_ROWS:  rd_val = 32'(igr_pkg::ARRAY_ROWS);
            igr_pkg::OFS_RED_COLS:  rd_val = 32'(rc);
            igr_pkg::OFS_RED_ROWS:  rd_val = 32'(rr);
            igr_pkg::OFS_TAPS:      rd_val = 32'(taps_ff);
            igr_pkg::OFS_CONV_TAPS: rd_val = 32'(ctaps_ff);
            igr_pkg::OFS_CODING:    rd_val = 32'(coding_ff);
            igr_pkg::OFS_BITS:      rd_val = 32'(igr_pkg::SAMPLE_BITS);
            igr_pkg::OFS_MASK:      rd_val = 32'(mask_ff);
            igr_pkg::OFS_FLOOR:     rd_val = 32'(igr_pkg::VALUE_FLOOR);
            igr_pkg::OFS_CEILING:   rd_val = 32'(igr_pkg::VALUE_CEILING);
            default:                rd_hit = 1'b0;
        endcase
    end
    // register writes; illegal values keep the old setting
    always_comb begin
        nxt_ctrl   = ctrl_ff;
        nxt_hbin   = hbin_ff;
        nxt_vbin   = vbin_ff;
        nxt_hsub   = hsub_ff;
        nxt_vsub   = vsub_ff;
        nxt_ccs    = ccs_ff;
        nxt_crs    = crs_ff;
        nxt_ccols  = ccols_ff;
        nxt_crows  = crows_ff;
        nxt_stride = stride_ff;
        nxt_coding = coding_ff;
        nxt_mask   = mask_ff;
        nxt_taps   = taps_ff;
        nxt_ctaps  = ctaps_ff;
        nxt_prdata = prdata_ff;
        nxt_perr   = perr_ff;
        if (setup) begin
            nxt_prdata = pwrite ? 32'h0 : rd_val;
            nxt_perr   = ~rd_hit;
        end
        if (wr) begin
            case (paddr)
                igr_pkg::OFS_CTRL: nxt_ctrl = pwdata[2:0];
                // factor writes that would shrink the image to nothing are ignored
                igr_pkg::OFS_H_COMBINE:
                    if (f_pow2(pwdata) &&
                        4'(f_log(pwdata[3:0])) + 4'(f_log(hsub_ff)) <= 4'(igr_pkg::COL_LOG))
                        nxt_hbin = pwdata[3:0];
                igr_pkg::OFS_H_SUB:
                    if (f_pow2(pwdata) &&
                        4'(f_log(pwdata[3:0])) + 4'(f_log(hbin_ff)) <= 4'(igr_pkg::COL_LOG))
                        nxt_hsub = pwdata[3:0];
                igr_pkg::OFS_V_COMBINE:
                    if (f_pow2(pwdata) &&
                        4'(f_log(pwdata[3:0])) + 4'(f_log(vsub_ff)) <= 4'(igr_pkg::ROW_LOG))
                        nxt_vbin = pwdata[3:0];
                igr_pkg::OFS_V_SUB:
                    if (f_pow2(pwdata) &&
                        4'(f_log(pwdata[3:0])) + 4'(f_log(vbin_ff)) <= 4'(igr_pkg::ROW_LOG))
                        nxt_vsub = pwdata[3:0];
                igr_pkg::OFS_COL_START: nxt_ccs   = pwdata[6:0];
                igr_pkg::OFS_ROW_START: nxt_crs   = pwdata[5:0];
                igr_pkg::OFS_CROP_COLS: nxt_ccols = pwdata[6:0];
                igr_pkg::OFS_CROP_ROWS: nxt_crows = pwdata[5:0];
                igr_pkg::OFS_STRIDE:    nxt_stride = pwdata[15:0];
                igr_pkg::OFS_LAYOUT:
                    // bits field is fixed by the container; geometry never moves
                    if (pwdata[igr_pkg::LAYOUT_CODING +: 8] <= igr_pkg::CODING_YUV &&
                        pwdata[igr_pkg::LAYOUT_MASK +: 8] <= igr_pkg::MASK_LAST) begin
                        nxt_coding = pwdata[igr_pkg::LAYOUT_CODING +: 8];
                        nxt_mask   = pwdata[igr_pkg::LAYOUT_MASK +: 8];
                    end
                igr_pkg::OFS_TAPS:
                    if (f_tap_ok(pwdata)) nxt_taps = pwdata[3:0];
                igr_pkg::OFS_CONV_TAPS:
                    if (f_tap_ok(pwdata)) nxt_ctaps = pwdata[3:0];
                default: ;
            endcase
        end
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_ff   <= 3'h0;
            hbin_ff   <= igr_pkg::FACTOR_ONE;
            vbin_ff   <= igr_pkg::FACTOR_ONE;
            hsub_ff   <= igr_pkg::FACTOR_ONE;
            vsub_ff   <= igr_pkg::FACTOR_ONE;
            ccs_ff    <= 7'h0;
            crs_ff    <= 6'h0;
            ccols_ff  <= igr_pkg::ARRAY_COLS;
            crows_ff  <= igr_pkg::ARRAY_ROWS;
            stride_ff <= 16'h0;
            coding_ff <= igr_pkg::CODING_MONO;
            mask_ff   <= igr_pkg::MASK_NONE;
            taps_ff   <= igr_pkg::FACTOR_ONE;
            ctaps_ff  <= igr_pkg::FACTOR_ONE;
            prdata_ff <= 32'h0;
            perr_ff   <= 1'b0;
        end else if (ce) begin
            ctrl_ff   <= nxt_ctrl;
            hbin_ff   <= nxt_hbin;
            vbin_ff   <= nxt_vbin;
            hsub_ff   <= nxt_hsub;
            vsub_ff   <= nxt_vsub;
            ccs_ff    <= nxt_ccs;
            crs_ff    <= nxt_crs;
            ccols_ff  <= nxt_ccols;
            crows_ff  <= nxt_crows;
            stride_ff <= nxt_stride;
            coding_ff <= nxt_coding;
            mask_ff   <= nxt_mask;
            taps_ff   <= nxt_taps;
            ctaps_ff  <= nxt_ctaps;
            prdata_ff <= nxt_prdata;
            perr_ff   <= nxt_perr;
        end
    end
    // frame store, then bin, mirror, crop and stride per output pixel
    always_comb begin
        nxt_st     = st_ff;
        nxt_fidx   = fidx_ff;
        nxt_oc     = oc_ff;
        nxt_or     = or_ff;
        nxt_bi     = bi_ff;
        nxt_bj     = bj_ff;
        nxt_acc    = acc_ff;
        nxt_pix    = pix_ff;
        nxt_byte   = byte_ff;
        nxt_pad    = pad_ff;
        nxt_frames = frames_ff;
        mem_we     = 1'b0;
        case (st_ff)
            igr_pkg::S_IDLE:
                if (ctrl_ff[igr_pkg::CTRL_RUN]) begin
                    nxt_st   = igr_pkg::S_FILL;
                    nxt_fidx = 11'h0;
                end
            igr_pkg::S_FILL:
                if (in_valid) begin
                    mem_we   = 1'b1;
                    nxt_fidx = 11'(fidx_ff + 11'h1);
                    if (fidx_ff == 11'(igr_pkg::MEM_DEPTH - 1)) begin
                        nxt_st  = igr_pkg::S_ACC;
                        nxt_oc  = 7'h0;
                        nxt_or  = 6'h0;
                        nxt_bi  = 3'h0;
                        nxt_bj  = 3'h0;
                        nxt_acc = 20'h0;
                    end
                end
            igr_pkg::S_ACC: begin
                nxt_acc = sum;
                if (bi_ff == 3'(hbin_ff - 4'h1)) begin
                    nxt_bi = 3'h0;
                    if (bj_ff == 3'(vbin_ff - 4'h1)) begin
                        nxt_bj   = 3'h0;
                        nxt_acc  = 20'h0;
                        nxt_pix  = sat;
                        nxt_byte = sat[7:0];
                        nxt_st   = igr_pkg::S_LO;
                    end else begin
                        nxt_bj = 3'(bj_ff + 3'h1);
                    end
                end else begin
                    nxt_bi = 3'(bi_ff + 3'h1);
                end
            end
            igr_pkg::S_LO:
                if (out_ready) begin
                    nxt_byte = pix_ff[15:8];
                    nxt_st   = igr_pkg::S_HI;
                end
            igr_pkg::S_HI:
                if (out_ready) begin
                    if (!last_col) begin
                        nxt_oc = 7'(oc_ff + 7'h1);
                        nxt_st = igr_pkg::S_ACC;
                    end else if (pad != 16'h0) begin
                        nxt_oc   = 7'h0;
                        nxt_pad  = pad;
                        nxt_byte = 8'h0;
                        nxt_st   = igr_pkg::S_PAD;
                    end else begin
                        nxt_oc = 7'h0;
                        nxt_or = 6'(or_ff + 6'h1);
                        nxt_st = last_row ? igr_pkg::S_IDLE : igr_pkg::S_ACC;
                        if (last_row) nxt_frames = 8'(frames_ff + 8'h1);
                    end
                end
            igr_pkg::S_PAD:
                if (out_ready) begin
                    nxt_pad = 16'(pad_ff - 16'h1);
                    if (pad_ff == 16'h1) begin
                        nxt_or = 6'(or_ff + 6'h1);
                        nxt_st = last_row ? igr_pkg::S_IDLE : igr_pkg::S_ACC;
                        if (last_row) nxt_frames = 8'(frames_ff + 8'h1);
                    end
                end
            default: nxt_st = igr_pkg::S_IDLE;
        endcase
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            st_ff     <= igr_pkg::S_IDLE;
            fidx_ff   <= 11'h0;
            oc_ff     <= 7'h0;
            or_ff     <= 6'h0;
            bi_ff     <= 3'h0;
            bj_ff     <= 3'h0;
            acc_ff    <= 20'h0;
            pix_ff    <= 16'h0;
            byte_ff   <= 8'h0;
            pad_ff    <= 16'h0;
            frames_ff <= 8'h0;
        end else if (ce) begin
            st_ff     <= nxt_st;
            fidx_ff   <= nxt_fidx;
            oc_ff     <= nxt_oc;
            or_ff     <= nxt_or;
            bi_ff     <= nxt_bi;
            bj_ff     <= nxt_bj;
            acc_ff    <= nxt_acc;
            pix_ff    <= nxt_pix;
            byte_ff   <= nxt_byte;
            pad_ff    <= nxt_pad;
            frames_ff <= nxt_frames;
        end
    end
    always_ff @(posedge clock) begin
        if (ce && mem_we) begin
            mem[fidx_ff] <= in_data;
        end
    end
    // handshakes are qualified by ce so a frozen block takes and gives nothing
    assign in_ready  = ce && (st_ff == igr_pkg::S_FILL);
    assign out_valid = ce && (st_ff == igr_pkg::S_LO || st_ff == igr_pkg::S_HI ||
                              st_ff == igr_pkg::S_PAD);
    assign out_data  = byte_ff;
    assign out_sof   = (st_ff == igr_pkg::S_LO) && (oc_ff == 7'h0) && (or_ff == 6'h0);
    assign out_eol   = ((st_ff == igr_pkg::S_HI) && last_col && (pad == 16'h0)) ||
                       ((st_ff == igr_pkg::S_PAD) && (pad_ff == 16'h1));
    assign out_eof   = out_eol && last_row;
endmodule

// ### verif/igr_asserts.sv
// Purpose: port checks for the geometry stage
// Assumes: read data is loaded at the setup edge
// Notes:   bound to every instance of the core
`timescale 1ns/100ps
module igr_asserts (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        out_valid,
    input wire logic        out_ready,
    input wire logic [7:0]  out_data,
    input wire logic        out_sof,
    input wire logic        out_eol,
    input wire logic        out_eof
);
    logic rs;
    assign rs = ce && psel && !penable && !pwrite;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    AST_ARR_COLS: assert property (
        rs && paddr == igr_pkg::OFS_ARR_COLS |=> prdata == 32'h40) else $error("bad width");
    AST_ARR_ROWS: assert property (
        rs && paddr == igr_pkg::OFS_ARR_ROWS |=> prdata == 32'h20) else $error("bad height");
    AST_FLOOR: assert property (
        rs && paddr == igr_pkg::OFS_FLOOR |=> prdata == 32'h0) else $error("bad floor");
    AST_CEILING: assert property (
        rs && paddr == igr_pkg::OFS_CEILING |=> prdata == 32'hFFF) else $error("bad ceiling");
    AST_RED_COLS: assert property (
        rs && paddr == igr_pkg::OFS_RED_COLS |=> prdata > 0 && prdata <= 32'h40)
        else $error("reduced width out of range");
    AST_RED_ROWS: assert property (
        rs && paddr == igr_pkg::OFS_RED_ROWS |=> prdata > 0 && prdata <= 32'h20)
        else $error("reduced height out of range");
    AST_HOLD: assert property (
        ce && out_valid && !out_ready |=> out_valid && $stable(out_data)) else $error("byte lost");
    AST_EOF: assert property (
        out_valid && out_eof |-> out_eol) else $error("frame end off a line end");
    AST_SOF: assert property (
        out_valid && out_ready && out_sof |=> !out_sof) else $error("frame start repeated");
    AST_EOF_LAST: assert property (
        out_valid && out_ready && out_eof |=> !out_valid) else $error("bytes after frame end");
endmodule
bind igr_core igr_asserts igr_asserts_i (.clock(clock), .rst(rst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .out_sof(out_sof), .out_eol(out_eol), .out_eof(out_eof));

// ### verif/igr_sensor.sv
// Purpose: sensor model feeding raster samples
// Assumes: each sample equals its raster index
// Notes:   slow mode offers a sample every other cycle
`timescale 1ns/100ps
module igr_sensor (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        slow,
    input  wire logic        in_ready,
    output logic             in_valid,
    output logic      [15:0] in_data
);
    logic [10:0] idx_ff;
    logic        ph_ff;
    assign in_valid = !slow || ph_ff;
    // idle bus shows the inverse so stale data is never taken
    assign in_data = in_valid ? {5'h00, idx_ff} : ~{5'h00, idx_ff};
    always_ff @(posedge clock) begin
        ph_ff <= rst ? 1'b0 : !ph_ff;
        if (rst)
            idx_ff <= 11'h000;
        else if (in_valid && in_ready)
            idx_ff <= idx_ff + 11'h001;
    end
endmodule

// ### verif/image_geometry_roi_pipeline_tb.sv
// Purpose: self-checking bench for the geometry stage
// Assumes: ce held high, sink stalls every other cycle
// Notes:   two mirrored cropped frames plus register checks
`timescale 1ns/100ps
module image_geometry_roi_pipeline_tb;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        out_ready = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q;
    logic [15:0] in_data;
    logic [7:0]  out_data;
    logic        pready, pslverr, in_valid, in_ready, out_valid, out_sof, out_eol, out_eof, e;
    logic [31:0] taps [6] = '{32'h1, 32'h2, 32'h3, 32'h4, 32'h8, 32'hA};
    int          bad_count = 0;
    int          compares = 0;
    int          cycles = 0;
    int          px;
    always #2.5 clock = ~clock;
    igr_core igr_core_i (.clock(clock), .rst(rst), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
        .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .out_sof(out_sof),
        .out_eol(out_eol), .out_eof(out_eof));
    igr_sensor igr_sensor_i (.clock(clock), .rst(rst), .slow(1'b1), .in_ready(in_ready),
        .in_valid(in_valid), .in_data(in_data));
    task conclude();
        if (bad_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(q, x);
    endtask
    // consumer stalls half the time so held bytes are exercised
    // looked at mid-cycle where outputs have settled; taken at the next rising edge
    task take(input int x, input logic [2:0] f);
        do @(negedge clock); while (!(out_valid === 1'b1 && out_ready === 1'b1));
        chk({24'h0, out_data}, x[31:0]);
        chk({29'h0, out_sof, out_eol, out_eof}, {29'h0, f});
        @(posedge clock);
    endtask
    always @(posedge clock) begin
        out_ready <= !out_ready;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            conclude();
        end
    end
    initial begin
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        rd(igr_pkg::OFS_ARR_COLS, 32'h40);
        rd(igr_pkg::OFS_ARR_ROWS, 32'h20);
        rd(igr_pkg::OFS_FLOOR, 32'h0);
        rd(igr_pkg::OFS_CEILING, 32'hFFF);
        rd(igr_pkg::OFS_BITS, 32'h10);
        apb(1'b1, igr_pkg::OFS_ARR_COLS, 32'h0);
        rd(igr_pkg::OFS_ARR_COLS, 32'h40);
        apb(1'b0, 8'hFC, 32'h0);
        chk({31'h0, e}, 32'h1);
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, igr_pkg::OFS_LAYOUT, {8'h00, 8'(k), 16'h0010});
            rd(igr_pkg::OFS_CODING, 32'(k));
            rd(igr_pkg::OFS_RED_COLS, 32'h40);
        end
        foreach (taps[i]) begin
            apb(1'b1, igr_pkg::OFS_TAPS, taps[i]);
            apb(1'b1, igr_pkg::OFS_CONV_TAPS, taps[i]);
            rd(igr_pkg::OFS_TAPS, taps[i]);
            rd(igr_pkg::OFS_CONV_TAPS, taps[i]);
        end
        apb(1'b1, igr_pkg::OFS_H_COMBINE, 32'h2);
        apb(1'b1, igr_pkg::OFS_COL_START, 32'h1);
        apb(1'b1, igr_pkg::OFS_ROW_START, 32'h2);
        apb(1'b1, igr_pkg::OFS_CROP_COLS, 32'h2);
        apb(1'b1, igr_pkg::OFS_CROP_ROWS, 32'h2);
        apb(1'b1, igr_pkg::OFS_STRIDE, 32'h6);
        rd(igr_pkg::OFS_RED_COLS, 32'h20);
        rd(igr_pkg::OFS_RED_ROWS, 32'h20);
        apb(1'b1, igr_pkg::OFS_CTRL, 32'h3);
        apb(1'b1, igr_pkg::OFS_CTRL, 32'h2);
        for (int r = 0; r < 2; r++) begin
            for (int b = 0; b < 6; b++) begin
                px = 2 * ((2 + r) * 64 + 2 * (30 - b / 2)) + 1;
                take(b > 3 ? 0 : (b % 2 ? px / 256 : px % 256),
                     {r == 0 && b == 0, b == 5, r == 1 && b == 5});
            end
        end
        rd(igr_pkg::OFS_STATUS, 32'h100);
        apb(1'b1, igr_pkg::OFS_COL_START, 32'h28);
        rd(igr_pkg::OFS_STATUS, 32'h102);
        apb(1'b1, igr_pkg::OFS_H_SUB, 32'h4);
        rd(igr_pkg::OFS_RED_COLS, 32'h8);
        apb(1'b1, igr_pkg::OFS_V_SUB, 32'h2);
        rd(igr_pkg::OFS_RED_ROWS, 32'h10);
        apb(1'b1, igr_pkg::OFS_CTRL, 32'h5);
        apb(1'b1, igr_pkg::OFS_CTRL, 32'h4);
        for (int r = 0; r < 2; r++) begin
            for (int b = 0; b < 6; b++) begin
                px = 2 * ((26 - 2 * r) * 64 + 56) + 1;
                take(b > 1 ? 0 : (b % 2 ? px / 256 : px % 256),
                     {r == 0 && b == 0, b == 5, r == 1 && b == 5});
            end
        end
        rd(igr_pkg::OFS_STATUS, 32'h202);
        conclude();
    end
endmodule
